// >>> logic/tmpio_top.sv
`timescale 1ns/1ps
`include "tmpio_cfg.svh"
module tmpio_top import tmpio_pkg::*; #(
	parameter int CE_FILT_CYC = `TMPIO_CE_FILT_CYC,
	parameter int TIMER_CYC = `TMPIO_TIMER_CYC,
	parameter int SYNC_GATE_CYC = `TMPIO_SYNC_GATE_CYC,
	parameter int SYNC_LO_CNT = `TMPIO_SYNC_LO_CNT,
	parameter int SYNC_HI_CNT = `TMPIO_SYNC_HI_CNT,
	parameter int AUX_STEP_CYC = `TMPIO_AUX_STEP_CYC,
	parameter int KNOB_DISCH_CYC = `TMPIO_KNOB_DISCH_CYC
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic cpu_op_valid_in,
	input wire tmpio_op_t cpu_op_in,
	input wire logic [1:0] cpu_bit_in,
	input wire logic [12:0] cpu_data_in,
	input wire logic ram_we_in,
	input wire logic [5:0] ram_addr_in,
	input wire logic [3:0] ram_wdata_in,
	output logic [3:0] cpu_rdata_out,
	output logic cpu_cond_out,
	output logic cpu_reset_out,
	output logic cpu_halt_out,
	input wire logic chip_enable_in,
	input wire logic [3:0] bitwise_bidir_port_in,
	output logic [3:0] bitwise_bidir_port_out,
	output logic [3:0] bitwise_bidir_port_oe_out,
	input wire logic [3:0] grouped_bidir_port_in,
	output logic [3:0] grouped_bidir_port_out,
	output logic [3:0] grouped_bidir_port_oe_out,
	output logic [2:0] three_bit_output_port_out,
	output logic [2:0] three_bit_output_port_oe_out,
	output logic [1:0] open_drain_output_port_oe_out,
	output logic [6:0] segment_drive_outputs_oe_out,
	input wire logic hsync_input_pin_in,
	output logic hsync_input_pin_out,
	output logic hsync_input_pin_oe_out,
	input wire logic remote_input_pin_in,
	input wire logic adc_cmp_in,
	output logic [3:0] adc_ref_out,
	output logic tuning_converter_out,
	output logic aux_converter_out
);
	generate
		if (CE_FILT_CYC < 2 || TIMER_CYC < 2 || SYNC_GATE_CYC < 2 || AUX_STEP_CYC < 1 ||
			KNOB_DISCH_CYC < 1 || SYNC_LO_CNT > SYNC_HI_CNT || SYNC_HI_CNT > 65535) begin : g_chk
			$error("tmpio_top: unsupported timing parameter");
		end
	endgenerate

	// segment pattern array, bit 0 = segment a; lit segment is pulled low
	function automatic logic [6:0] seg_pattern(input logic [4:0] idx);
		case (idx)
			5'h00: seg_pattern = 7'h3f;
			5'h01: seg_pattern = 7'h06;
			5'h02: seg_pattern = 7'h5b;
			5'h03: seg_pattern = 7'h4f;
			5'h04: seg_pattern = 7'h66;
			5'h05: seg_pattern = 7'h6d;
			5'h06: seg_pattern = 7'h7d;
			5'h07: seg_pattern = 7'h07;
			5'h08: seg_pattern = 7'h7f;
			5'h09: seg_pattern = 7'h6f;
			5'h0a: seg_pattern = 7'h77;
			5'h0b: seg_pattern = 7'h7c;
			5'h0c: seg_pattern = 7'h39;
			5'h0d: seg_pattern = 7'h5e;
			5'h0e: seg_pattern = 7'h79;
			5'h0f: seg_pattern = 7'h71;
			5'h10: seg_pattern = 7'h40;
			5'h11: seg_pattern = 7'h08;
			5'h12: seg_pattern = 7'h01;
			default: seg_pattern = 7'h00;
		endcase
	endfunction

	// operation decode
	logic op_go;
	assign op_go = clk_en_in & cpu_op_valid_in & ~cpu_halt_out;
	wire op_in_a = op_go && cpu_op_in == TMPIO_OP_IN_A;
	wire op_out_a = op_go && cpu_op_in == TMPIO_OP_OUT_A;
	wire op_in_b = op_go && cpu_op_in == TMPIO_OP_IN_B;
	wire op_out_b = op_go && cpu_op_in == TMPIO_OP_OUT_B;
	wire op_set_b = op_go && cpu_op_in == TMPIO_OP_SET_B;
	wire op_clr_b = op_go && cpu_op_in == TMPIO_OP_CLR_B;
	wire op_out_c = op_go && cpu_op_in == TMPIO_OP_OUT_C;
	wire op_out_m = op_go && cpu_op_in == TMPIO_OP_OUT_M;
	wire op_seg = op_go && cpu_op_in == TMPIO_OP_SEG;
	wire op_halt = op_go && cpu_op_in == TMPIO_OP_HALT;
	wire op_t_rem = op_go && cpu_op_in == TMPIO_OP_TEST_REMOTE;
	wire op_t_sync = op_go && cpu_op_in == TMPIO_OP_TEST_SYNC;
	wire op_mode = op_go && cpu_op_in == TMPIO_OP_SET_MODE;
	wire op_tune = op_go && cpu_op_in == TMPIO_OP_TUNE;
	wire op_aux = op_go && cpu_op_in == TMPIO_OP_AUX;
	wire op_adc = op_go && cpu_op_in == TMPIO_OP_ADC_REF;
	wire op_t_adc = op_go && cpu_op_in == TMPIO_OP_TEST_ADC;
	wire dir_wr = clk_en_in && ram_we_in && ram_addr_in == `TMPIO_DIR_WORD_ADDR;

	// chip-select synchroniser and glitch filter
	logic ce_s1_q, ce_s2_q, ce_lvl_q;
	logic [31:0] ce_cnt_q;
	wire ce_diff = ce_s2_q != ce_lvl_q;
	wire ce_accept = ce_diff && ce_cnt_q == 32'(CE_FILT_CYC - 1);
	wire ce_rise = ce_accept & ce_s2_q;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ce_s1_q <= 1'b0;
			ce_s2_q <= 1'b0;
			ce_lvl_q <= 1'b0;
			ce_cnt_q <= '0;
		end else if (clk_en_in) begin
			ce_s1_q <= chip_enable_in;
			ce_s2_q <= ce_s1_q;
			if (!ce_diff || ce_accept) begin
				ce_cnt_q <= '0;
			end else begin
				ce_cnt_q <= ce_cnt_q + 32'h1;
			end
			if (ce_accept) begin
				ce_lvl_q <= ce_s2_q;
			end
		end
	end

	// 125 ms timer event and chip-select reset
	logic [31:0] tmr_cnt_q;
	logic ce_pend_q;
	wire tmr_tick = tmr_cnt_q == 32'(TIMER_CYC - 1);
	wire ce_reset = ce_pend_q & tmr_tick;
	wire halt_ev = op_halt;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tmr_cnt_q <= '0;
			ce_pend_q <= 1'b0;
			cpu_reset_out <= 1'b1;
			cpu_halt_out <= 1'b0;
		end else if (clk_en_in) begin
			tmr_cnt_q <= tmr_tick ? 32'h0 : tmr_cnt_q + 32'h1;
			if (ce_rise) begin
				ce_pend_q <= 1'b1;
			end else if (tmr_tick) begin
				ce_pend_q <= 1'b0;
			end
			cpu_reset_out <= ce_reset;
			if (ce_reset) begin
				cpu_halt_out <= 1'b0;
			end else if (halt_ev && !ce_lvl_q) begin
				cpu_halt_out <= 1'b1;
			end
		end
	end

	// bitwise and grouped bidirectional ports
	logic [3:0] pa_dir_q, pa_latch_q, pb_latch_q;
	logic pa_dir_ok_q, pb_out_q;
	wire port_in_force = ce_reset | halt_ev;
	wire [3:0] pb_bit = 4'h1 << cpu_bit_in;
	wire [3:0] pa_oe_d = pa_dir_ok_q ? pa_dir_q : 4'h0;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pa_dir_q <= `TMPIO_DIR_RST;
			pa_dir_ok_q <= 1'b0;
			pa_latch_q <= 4'h0;
			pb_latch_q <= 4'h0;
			pb_out_q <= 1'b0;
			bitwise_bidir_port_out <= 4'h0;
			bitwise_bidir_port_oe_out <= 4'h0;
			grouped_bidir_port_out <= 4'h0;
			grouped_bidir_port_oe_out <= 4'h0;
		end else if (clk_en_in) begin
			if (dir_wr) begin
				pa_dir_q <= ram_wdata_in;
			end
			if (port_in_force) begin
				pa_dir_ok_q <= 1'b0;
			end else if (dir_wr) begin
				pa_dir_ok_q <= 1'b1;
			end
			if (op_out_a) begin
				pa_latch_q <= cpu_data_in[3:0];
			end
			if (op_out_b) begin
				pb_latch_q <= cpu_data_in[3:0];
			end else if (op_set_b) begin
				pb_latch_q <= pb_latch_q | pb_bit;
			end else if (op_clr_b) begin
				pb_latch_q <= pb_latch_q & ~pb_bit;
			end
			if (port_in_force || op_in_b) begin
				pb_out_q <= 1'b0;
			end else if (op_out_b || op_set_b || op_clr_b) begin
				pb_out_q <= 1'b1;
			end
			bitwise_bidir_port_out <= pa_latch_q;
			bitwise_bidir_port_oe_out <= pa_oe_d;
			grouped_bidir_port_out <= pb_latch_q;
			grouped_bidir_port_oe_out <= {4{pb_out_q}};
		end
	end

	// output-only ports: floated by power-on and halt, kept on chip-select reset
	logic [2:0] pc_q;
	logic [1:0] pm_q;
	logic pc_drv_q, pm_drv_q;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pc_q <= 3'h0;
			pm_q <= 2'h0;
			pc_drv_q <= 1'b0;
			pm_drv_q <= 1'b0;
			three_bit_output_port_out <= 3'h0;
			three_bit_output_port_oe_out <= 3'h0;
			open_drain_output_port_oe_out <= 2'h0;
		end else if (clk_en_in) begin
			if (op_out_c) begin
				pc_q <= cpu_data_in[2:0];
			end
			if (op_out_m) begin
				pm_q <= cpu_data_in[1:0];
			end
			if (halt_ev) begin
				pc_drv_q <= 1'b0;
				pm_drv_q <= 1'b0;
			end else begin
				pc_drv_q <= pc_drv_q | op_out_c;
				pm_drv_q <= pm_drv_q | op_out_m;
			end
			three_bit_output_port_out <= pc_q;
			three_bit_output_port_oe_out <= {3{pc_drv_q}};
			open_drain_output_port_oe_out <= {2{pm_drv_q}} & ~pm_q;
		end
	end

	// segments, mode, tests and comparator reference
	logic [6:0] seg_pat_q;
	logic mode_q, sync_lock_q;
	logic [12:0] tune_val_q, knob_val_q;
	logic [5:0] aux_val_q;
	wire [3:0] pa_read = (bitwise_bidir_port_in & ~bitwise_bidir_port_oe_out) |
		(pa_latch_q & bitwise_bidir_port_oe_out);
	wire [3:0] pb_read = pb_out_q ? pb_latch_q : grouped_bidir_port_in;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			seg_pat_q <= 7'h00;
			mode_q <= `TMPIO_MODE_RST;
			tune_val_q <= `TMPIO_TUNE_RST;
			aux_val_q <= `TMPIO_AUX_RST;
			cpu_rdata_out <= 4'h0;
			cpu_cond_out <= 1'b0;
			adc_ref_out <= 4'h0;
			segment_drive_outputs_oe_out <= 7'h00;
		end else if (clk_en_in) begin
			if (op_seg) begin
				seg_pat_q <= seg_pattern(cpu_data_in[4:0]);
			end
			if (op_mode) begin
				mode_q <= cpu_data_in[0];
			end
			if (op_tune) begin
				tune_val_q <= cpu_data_in;
			end
			if (op_aux) begin
				aux_val_q <= cpu_data_in[5:0];
			end
			if (op_adc) begin
				adc_ref_out <= cpu_data_in[3:0];
			end
			if (op_in_a) begin
				cpu_rdata_out <= pa_read;
			end else if (op_in_b) begin
				cpu_rdata_out <= pb_read;
			end
			if (op_t_rem) begin
				cpu_cond_out <= remote_input_pin_in;
			end else if (op_t_sync) begin
				cpu_cond_out <= sync_lock_q;
			end else if (op_t_adc) begin
				cpu_cond_out <= adc_cmp_in;
			end
			segment_drive_outputs_oe_out <= ce_lvl_q ? seg_pat_q : 7'h00;
		end
	end

	// sync frequency detector and knob timing share the sync pin
	logic hs_prev_q;
	logic [31:0] gate_cnt_q, kn_tmr_q;
	logic [15:0] edge_cnt_q;
	logic [12:0] kn_cnt_q;
	tmpio_knob_t kn_q;
	wire gate_end = gate_cnt_q == 32'(SYNC_GATE_CYC - 1);
	wire hs_rise = hsync_input_pin_in & ~hs_prev_q;
	wire in_band = edge_cnt_q >= 16'(SYNC_LO_CNT) && edge_cnt_q <= 16'(SYNC_HI_CNT);

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hs_prev_q <= 1'b0;
			gate_cnt_q <= '0;
			edge_cnt_q <= '0;
			sync_lock_q <= 1'b0;
		end else if (clk_en_in) begin
			hs_prev_q <= hsync_input_pin_in;
			if (mode_q) begin
				gate_cnt_q <= '0;
				edge_cnt_q <= '0;
			end else if (gate_end) begin
				gate_cnt_q <= '0;
				edge_cnt_q <= '0;
				sync_lock_q <= in_band;
			end else begin
				gate_cnt_q <= gate_cnt_q + 32'h1;
				if (hs_rise && edge_cnt_q != 16'hffff) begin
					edge_cnt_q <= edge_cnt_q + 16'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			kn_q <= TMPIO_KN_DISCH;
			kn_tmr_q <= '0;
			kn_cnt_q <= '0;
			knob_val_q <= '0;
			hsync_input_pin_out <= 1'b0;
			hsync_input_pin_oe_out <= 1'b0;
		end else if (clk_en_in) begin
			hsync_input_pin_out <= 1'b0;
			hsync_input_pin_oe_out <= mode_q && kn_q == TMPIO_KN_DISCH;
			if (!mode_q) begin
				kn_q <= TMPIO_KN_DISCH;
				kn_tmr_q <= '0;
			end else begin
				case (kn_q)
					TMPIO_KN_DISCH: begin
						kn_cnt_q <= '0;
						if (kn_tmr_q == 32'(KNOB_DISCH_CYC - 1)) begin
							kn_tmr_q <= '0;
							kn_q <= TMPIO_KN_CHARGE;
						end else begin
							kn_tmr_q <= kn_tmr_q + 32'h1;
						end
					end
					TMPIO_KN_CHARGE: begin
						// charge time to threshold measures the knob resistance
						if (hsync_input_pin_in || kn_cnt_q == 13'h1fff) begin
							kn_q <= TMPIO_KN_LATCH;
						end else begin
							kn_cnt_q <= kn_cnt_q + 13'h1;
						end
					end
					TMPIO_KN_LATCH: begin
						knob_val_q <= kn_cnt_q;
						kn_q <= TMPIO_KN_DISCH;
					end
					default: kn_q <= TMPIO_KN_DISCH;
				endcase
			end
		end
	end

	// tuning converter: 8-bit pwm frame, rate multiplier adds a count in tune_src[4:0] of every 32 frames
	tmpio_rmp_if #(.W(5)) tune_rmp();
	tmpio_rmp_if #(.W(6)) aux_rmp();
	logic [7:0] pw_q;
	logic extra_q, tune_force_q, aux_force_q, aux_hold_q;
	logic [31:0] aux_div_q;
	wire [12:0] tune_src = mode_q ? knob_val_q : tune_val_q;
	wire frame_end = pw_q == 8'hff;
	wire pwm_bit = pw_q < tune_src[12:5] || (pw_q == tune_src[12:5] && extra_q);
	wire aux_step = aux_div_q == 32'(AUX_STEP_CYC - 1);
	assign tune_rmp.step = frame_end;
	assign tune_rmp.value = tune_src[4:0];
	assign aux_rmp.step = aux_step;
	assign aux_rmp.value = aux_val_q;

	tmpio_rmp #(.W(5)) u_tune_rmp (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.rmp(tune_rmp)
	);

	tmpio_rmp #(.W(6)) u_aux_rmp (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.rmp(aux_rmp)
	);

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pw_q <= 8'h00;
			extra_q <= 1'b0;
			aux_div_q <= '0;
			aux_hold_q <= 1'b0;
			tune_force_q <= 1'b1;
			aux_force_q <= 1'b1;
			tuning_converter_out <= 1'b1;
			aux_converter_out <= 1'b0;
		end else if (clk_en_in) begin
			pw_q <= pw_q + 8'h1;
			if (frame_end) begin
				extra_q <= tune_rmp.pulse;
			end
			aux_div_q <= aux_step ? 32'h0 : aux_div_q + 32'h1;
			aux_hold_q <= aux_rmp.pulse;
			if (op_tune || op_mode) begin
				tune_force_q <= 1'b0;
			end
			if (op_aux) begin
				aux_force_q <= 1'b0;
			end
			tuning_converter_out <= (cpu_halt_out || tune_force_q) ? 1'b1 : pwm_bit;
			aux_converter_out <= (cpu_halt_out || aux_force_q) ? 1'b0 : aux_hold_q;
		end
	end
endmodule

// >>> logic/tmpio_cfg.svh
`ifndef TMPIO_CFG_SVH
`define TMPIO_CFG_SVH

`define TMPIO_CLK_HZ 100000000
`define TMPIO_DIR_WORD_ADDR 6'h1f
`define TMPIO_DIR_RST 4'h0
`define TMPIO_MODE_RST 1'b0
`define TMPIO_TUNE_RST 13'h0000
`define TMPIO_AUX_RST 6'h00
// chip-select glitch limit, shortest accepted level
`define TMPIO_CE_FILT_NS 134000
`define TMPIO_CE_FILT_CYC ((`TMPIO_CE_FILT_NS * (`TMPIO_CLK_HZ / 1000000) + 999) / 1000)
`define TMPIO_TIMER_MS 125
`define TMPIO_TIMER_CYC (`TMPIO_TIMER_MS * (`TMPIO_CLK_HZ / 1000))
`define TMPIO_SYNC_GATE_MS 10
`define TMPIO_SYNC_GATE_CYC (`TMPIO_SYNC_GATE_MS * (`TMPIO_CLK_HZ / 1000))
`define TMPIO_SYNC_LO_HZ 14832
`define TMPIO_SYNC_HI_HZ 16480
`define TMPIO_SYNC_LO_CNT (`TMPIO_SYNC_LO_HZ * `TMPIO_SYNC_GATE_MS / 1000)
`define TMPIO_SYNC_HI_CNT (`TMPIO_SYNC_HI_HZ * `TMPIO_SYNC_GATE_MS / 1000)
`define TMPIO_AUX_HZ 1400
`define TMPIO_AUX_LEVELS 64
`define TMPIO_AUX_STEP_CYC (`TMPIO_CLK_HZ / (`TMPIO_AUX_HZ * `TMPIO_AUX_LEVELS))
`define TMPIO_KNOB_DISCH_NS 10000
`define TMPIO_KNOB_DISCH_CYC (`TMPIO_KNOB_DISCH_NS / (1000000000 / `TMPIO_CLK_HZ))

`endif

// >>> logic/tmpio_pkg.sv
package tmpio_pkg;

	typedef enum logic [4:0] {
		TMPIO_OP_NONE = 5'h00,
		TMPIO_OP_IN_A = 5'h01,
		TMPIO_OP_OUT_A = 5'h02,
		TMPIO_OP_IN_B = 5'h03,
		TMPIO_OP_OUT_B = 5'h04,
		TMPIO_OP_SET_B = 5'h05,
		TMPIO_OP_CLR_B = 5'h06,
		TMPIO_OP_OUT_C = 5'h07,
		TMPIO_OP_OUT_M = 5'h08,
		TMPIO_OP_SEG = 5'h09,
		TMPIO_OP_HALT = 5'h0a,
		TMPIO_OP_TEST_REMOTE = 5'h0b,
		TMPIO_OP_TEST_SYNC = 5'h0c,
		TMPIO_OP_SET_MODE = 5'h0d,
		TMPIO_OP_TUNE = 5'h0e,
		TMPIO_OP_AUX = 5'h0f,
		TMPIO_OP_ADC_REF = 5'h10,
		TMPIO_OP_TEST_ADC = 5'h11
	} tmpio_op_t;

	typedef enum logic [1:0] {
		TMPIO_KN_DISCH = 2'b00,
		TMPIO_KN_CHARGE = 2'b01,
		TMPIO_KN_LATCH = 2'b11
	} tmpio_knob_t;

endpackage

// >>> logic/tmpio_rmp_if.sv
`timescale 1ns/1ps
interface tmpio_rmp_if #(parameter int W = 5);
	logic step;
	logic [W-1:0] value;
	logic pulse;
	modport client (output step, output value, input pulse);
	modport core (input step, input value, output pulse);
endinterface

// >>> logic/tmpio_rmp.sv
`timescale 1ns/1ps
module tmpio_rmp #(
	parameter int W = 5
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	tmpio_rmp_if.core rmp
);
	logic [W-1:0] cnt_q;
	logic pulse_q;
	logic hit;

	// the lowest set counter bit picks which value bit may fire this step
	always_comb begin
		logic found;
		found = 1'b0;
		hit = 1'b0;
		for (int i = 0; i < W; i++) begin
			if (!found && cnt_q[i]) begin
				found = 1'b1;
				hit = rmp.value[W-1-i];
			end
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_q <= '0;
			pulse_q <= 1'b0;
		end else if (clk_en_in && rmp.step) begin
			cnt_q <= cnt_q + 1'b1;
			pulse_q <= hit;
		end
	end

	assign rmp.pulse = pulse_q;
endmodule

// >>> bench/tmpio_top_properties.sv
`timescale 1ns/1ps
module tmpio_top_properties import tmpio_pkg::*; #(
	parameter int CE_FILT_CYC = 8
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic cpu_op_valid_in,
	input wire tmpio_op_t cpu_op_in,
	input wire logic [12:0] cpu_data_in,
	input wire logic ram_we_in,
	input wire logic [5:0] ram_addr_in,
	input wire logic [3:0] ram_wdata_in,
	input wire logic cpu_reset_out,
	input wire logic cpu_halt_out,
	input wire logic chip_enable_in,
	input wire logic [3:0] bitwise_bidir_port_oe_out,
	input wire logic [3:0] grouped_bidir_port_out,
	input wire logic [3:0] grouped_bidir_port_oe_out,
	input wire logic [2:0] three_bit_output_port_oe_out,
	input wire logic [1:0] open_drain_output_port_oe_out,
	input wire logic [6:0] segment_drive_outputs_oe_out,
	input wire logic tuning_converter_out,
	input wire logic aux_converter_out
);
	logic [15:0] ce_lo_q;
	logic [15:0] ce_hi_q;
	logic [3:0] dir_q;
	wire op_go = clk_en_in && cpu_op_valid_in && !cpu_halt_out;
	wire dir_wr = clk_en_in && ram_we_in && ram_addr_in == 6'h1f;
	wire [3:0] op_nib = cpu_data_in[3:0];
	wire cm_off = three_bit_output_port_oe_out == 3'h0 && open_drain_output_port_oe_out == 2'h0;
	wire ab_in = bitwise_bidir_port_oe_out == 4'h0 && grouped_bidir_port_oe_out == 4'h0;
	// saturating run lengths of the raw chip-select level
	wire [15:0] ce_lo_d = chip_enable_in ? 16'h0000 : ce_lo_q + 16'(ce_lo_q != 16'hffff);
	wire [15:0] ce_hi_d = chip_enable_in ? ce_hi_q + 16'(ce_hi_q != 16'hffff) : 16'h0000;
	wire [3:0] dir_d = dir_wr ? ram_wdata_in : dir_q;
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ce_lo_q <= 16'h0000;
			ce_hi_q <= 16'h0000;
			dir_q <= 4'h0;
		end else begin
			ce_lo_q <= ce_lo_d;
			ce_hi_q <= ce_hi_d;
			dir_q <= dir_d;
		end
	end
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);
	chk_halt_state_held: assert property (
		cpu_halt_out && $past(cpu_halt_out) |-> tuning_converter_out && !aux_converter_out
		&& cm_off && ab_in) else $error("halted outputs wrong");
	chk_halt_op_floats: assert property (
		op_go && cpu_op_in == TMPIO_OP_HALT |-> ##2 cm_off && ab_in)
		else $error("halt op left a port driving");
	chk_grouped_out_op: assert property (
		op_go && cpu_op_in == TMPIO_OP_OUT_B |-> ##2 grouped_bidir_port_oe_out == 4'hf
		&& grouped_bidir_port_out == $past(op_nib, 2)) else $error("grouped out wrong");
	chk_grouped_in_op: assert property (
		op_go && cpu_op_in == TMPIO_OP_IN_B |-> ##2 grouped_bidir_port_oe_out == 4'h0)
		else $error("grouped in left drive on");
	chk_dir_word_oe: assert property (
		dir_wr |-> ##2 bitwise_bidir_port_oe_out == dir_q)
		else $error("bitwise direction mismatch");
	chk_ce_low_segs: assert property (
		ce_lo_q > CE_FILT_CYC + 3 |-> segment_drive_outputs_oe_out == 7'h00)
		else $error("segments on with chip-select low");
	chk_ce_filtered: assert property (
		$rose(cpu_reset_out) |-> ce_hi_q >= CE_FILT_CYC)
		else $error("reset from short chip-select level");
	chk_cs_reset_input: assert property (
		$rose(cpu_reset_out) |=> ab_in) else $error("bidir port driving after reset");
	chk_cs_keeps_outs: assert property (
		$rose(cpu_reset_out) |=> ($stable(three_bit_output_port_oe_out)
		&& $stable(open_drain_output_port_oe_out)) [*2]) else $error("output port changed");
	chk_reset_one_pulse: assert property (
		$rose(cpu_reset_out) |=> !cpu_reset_out) else $error("reset pulse too long");
	cover property (op_go && cpu_op_in == TMPIO_OP_HALT);
	cover property ($rose(cpu_reset_out));
	cover property (dir_wr);
endmodule

bind tmpio_top tmpio_top_properties #(.CE_FILT_CYC(CE_FILT_CYC)) u_props (
	.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
	.cpu_op_valid_in(cpu_op_valid_in), .cpu_op_in(cpu_op_in), .cpu_data_in(cpu_data_in),
	.ram_we_in(ram_we_in), .ram_addr_in(ram_addr_in), .ram_wdata_in(ram_wdata_in),
	.cpu_reset_out(cpu_reset_out), .cpu_halt_out(cpu_halt_out), .chip_enable_in(chip_enable_in),
	.bitwise_bidir_port_oe_out(bitwise_bidir_port_oe_out),
	.grouped_bidir_port_out(grouped_bidir_port_out),
	.grouped_bidir_port_oe_out(grouped_bidir_port_oe_out),
	.three_bit_output_port_oe_out(three_bit_output_port_oe_out),
	.open_drain_output_port_oe_out(open_drain_output_port_oe_out),
	.segment_drive_outputs_oe_out(segment_drive_outputs_oe_out),
	.tuning_converter_out(tuning_converter_out), .aux_converter_out(aux_converter_out));

// >>> bench/tmpio_far_model.sv
`timescale 1ns/1ps
module tmpio_far_model #(
	parameter int KNOB_NS = 300
) (
	input wire logic [3:0] a_out_in,
	input wire logic [3:0] a_oe_in,
	input wire logic [3:0] b_out_in,
	input wire logic [3:0] b_oe_in,
	input wire logic hs_oe_in,
	input wire logic [3:0] adc_ref_in,
	input wire logic [3:0] key_a_in,
	input wire logic [3:0] key_b_in,
	input wire logic [7:0] hs_half_in,
	input wire logic [3:0] level_in,
	output logic [3:0] a_pin_out,
	output logic [3:0] b_pin_out,
	output logic hs_pin_out,
	output logic cmp_out
);
	logic gen_q = 1'b0;
	logic rc_q = 1'b1;
	// released pins show the external key levels
	assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & key_a_in);
	assign b_pin_out = (b_oe_in & b_out_in) | (~b_oe_in & key_b_in);
	// zero half period selects the knob network instead of the sync source
	assign hs_pin_out = hs_oe_in ? 1'b0 : (hs_half_in == 8'h00 ? rc_q : gen_q);
	assign cmp_out = level_in >= adc_ref_in;
	initial forever begin
		if (hs_half_in > 8'h00)
			#(hs_half_in) gen_q = ~gen_q;
		else
			#10;
	end
	// capacitor recharges to the threshold a fixed time after release
	always @(hs_oe_in) begin
		rc_q = 1'b0;
		if (!hs_oe_in)
			rc_q <= #(KNOB_NS) 1'b1;
	end
endmodule

// >>> bench/tmpio_top_tb_top.sv
`timescale 1ns/1ps
module tmpio_top_tb_top import tmpio_pkg::*; ;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1, clk_en_in = 1'b1, valid = 1'b0, we = 1'b0, ce = 1'b0;
	logic remote = 1'b0, cmp, hs_pin, cond, rst_o, halt_o, hs_o, hs_oe, tune, aux;
	tmpio_op_t op = TMPIO_OP_NONE;
	logic [1:0] bsel = 2'h0, m_oe;
	logic [12:0] data = 13'h0000;
	logic [5:0] addr = 6'h00;
	logic [3:0] wdata = 4'h0, key_a = 4'h9, key_b = 4'h3, lvl = 4'h7;
	logic [3:0] a_pin, b_pin, rdata, a_out, a_oe, b_out, b_oe, adc_ref;
	logic [2:0] c_out, c_oe;
	logic [6:0] seg_oe;
	logic [7:0] hs_half = 8'h41;
	logic [7:0] half_t [3] = '{8'h41, 8'h50, 8'h3c};
	logic [2:0] lock_m = 3'b001;
	int n_errors = 0;
	int checked = 0;
	tmpio_top #(.CE_FILT_CYC(8), .TIMER_CYC(200), .SYNC_GATE_CYC(2000), .AUX_STEP_CYC(2)) DUT (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
		.cpu_op_valid_in(valid), .cpu_op_in(op), .cpu_bit_in(bsel), .cpu_data_in(data),
		.ram_we_in(we), .ram_addr_in(addr), .ram_wdata_in(wdata), .cpu_rdata_out(rdata),
		.cpu_cond_out(cond), .cpu_reset_out(rst_o), .cpu_halt_out(halt_o), .chip_enable_in(ce),
		.bitwise_bidir_port_in(a_pin), .bitwise_bidir_port_out(a_out),
		.bitwise_bidir_port_oe_out(a_oe), .grouped_bidir_port_in(b_pin),
		.grouped_bidir_port_out(b_out), .grouped_bidir_port_oe_out(b_oe),
		.three_bit_output_port_out(c_out), .three_bit_output_port_oe_out(c_oe),
		.open_drain_output_port_oe_out(m_oe), .segment_drive_outputs_oe_out(seg_oe),
		.hsync_input_pin_in(hs_pin), .hsync_input_pin_out(hs_o), .hsync_input_pin_oe_out(hs_oe),
		.remote_input_pin_in(remote), .adc_cmp_in(cmp), .adc_ref_out(adc_ref),
		.tuning_converter_out(tune), .aux_converter_out(aux));
	tmpio_far_model u_far (.a_out_in(a_out), .a_oe_in(a_oe), .b_out_in(b_out),
		.b_oe_in(b_oe), .hs_oe_in(hs_oe), .adc_ref_in(adc_ref), .key_a_in(key_a),
		.key_b_in(key_b), .hs_half_in(hs_half), .level_in(lvl), .a_pin_out(a_pin),
		.b_pin_out(b_pin), .hs_pin_out(hs_pin), .cmp_out(cmp));
	initial forever #5 mclk_in = ~mclk_in;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic do_op(input tmpio_op_t o, input logic [12:0] d, input logic [1:0] b);
		@(negedge mclk_in);
		valid = 1'b1;
		op = o;
		data = d;
		bsel = b;
		@(negedge mclk_in);
		valid = 1'b0;
		cyc(2);
	endtask
	task automatic ram_wr(input logic [5:0] a, input logic [3:0] d);
		@(negedge mclk_in);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge mclk_in);
		we = 1'b0;
		cyc(3);
	endtask
	task automatic count_hi(input logic sel, input int n, output int k);
		k = 0;
		repeat (n) begin
			@(negedge mclk_in);
			if ((sel ? aux : tune) === 1'b1)
				k++;
		end
	endtask
	task automatic wait_rst();
		int i;
		for (i = 0; i < 400 && rst_o !== 1'b1; i++)
			cyc(1);
		chk(rst_o, 1'b1, "chip-select reset pulse");
		cyc(3);
	endtask
	task automatic done(input string name);
		$display("test %s ended, mismatches %0d", name, n_errors);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#500000;
		n_errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		int i, k;
		logic [3:0] r;
		cyc(6);
		chk({rst_o, tune, aux}, 3'b110, "reset converter levels");
		chk({a_oe, b_oe, c_oe, m_oe}, 13'h0000, "reset drive");
		cyc(6);
		sys_rst_in = 1'b0;
		cyc(3);
		chk(rst_o, 1'b0, "reset released");
		count_hi(1'b0, 20, k);
		chk(k, 20, "tuning idle high");
		done("reset");
		ram_wr(6'h1f, 4'h5);
		chk(a_oe, 4'h5, "direction word");
		ram_wr(6'h1e, 4'h2);
		chk(a_oe, 4'h5, "other address ignored");
		do_op(TMPIO_OP_OUT_A, 13'h000a, 2'h0);
		do_op(TMPIO_OP_IN_A, 13'h0000, 2'h0);
		chk(rdata, 4'h8, "bitwise pin mix");
		key_a = 4'h6;
		do_op(TMPIO_OP_IN_A, 13'h0000, 2'h0);
		chk(rdata, 4'h2, "bitwise pin mix");
		do_op(TMPIO_OP_OUT_B, 13'h0005, 2'h0);
		chk({b_oe, b_out}, 8'hf5, "grouped out");
		do_op(TMPIO_OP_SET_B, 13'h0000, 2'h1);
		chk(b_out, 4'h7, "grouped bit set");
		do_op(TMPIO_OP_CLR_B, 13'h0000, 2'h0);
		chk(b_out, 4'h6, "grouped bit clear");
		do_op(TMPIO_OP_IN_B, 13'h0000, 2'h0);
		key_b = 4'hc;
		do_op(TMPIO_OP_IN_B, 13'h0000, 2'h0);
		chk({b_oe, rdata}, 8'h0c, "grouped in");
		do_op(TMPIO_OP_OUT_C, 13'h0005, 2'h0);
		chk({c_oe, c_out}, 6'h3d, "port c");
		clk_en_in = 1'b0;
		do_op(TMPIO_OP_OUT_C, 13'h0002, 2'h0);
		chk(c_out, 3'h5, "enable low freezes");
		clk_en_in = 1'b1;
		do_op(TMPIO_OP_OUT_M, 13'h0001, 2'h0);
		chk(m_oe, 2'h2, "port m");
		done("ports");
		for (i = 0; i < 2; i++) begin
			remote = i[0];
			do_op(TMPIO_OP_TEST_REMOTE, 13'h0000, 2'h0);
			chk(cond, i[0], "remote test");
			r = i ? 4'hc : 4'h3;
			lvl = i ? 4'hd : 4'h2;
			do_op(TMPIO_OP_ADC_REF, {9'h000, r}, 2'h0);
			chk(adc_ref, r, "adc reference");
			do_op(TMPIO_OP_TEST_ADC, 13'h0000, 2'h0);
			chk(cond, lvl >= r, "adc compare");
		end
		done("tests");
		do_op(TMPIO_OP_SET_MODE, 13'h0000, 2'h0);
		for (i = 0; i < 3; i++) begin
			hs_half = half_t[i];
			cyc(4200);
			do_op(TMPIO_OP_TEST_SYNC, 13'h0000, 2'h0);
			chk(cond, lock_m[i], "sync lock");
		end
		do_op(TMPIO_OP_SET_MODE, 13'h0001, 2'h0);
		hs_half = 8'h00;
		for (i = 0; i < 200 && hs_oe !== 1'b1; i++)
			cyc(1);
		chk({hs_oe, hs_o}, 2'b10, "knob discharge");
		do_op(TMPIO_OP_SET_MODE, 13'h0000, 2'h0);
		hs_half = 8'h41;
		done("sync");
		do_op(TMPIO_OP_TUNE, 13'h0405, 2'h0);
		cyc(512);
		count_hi(1'b0, 8192, k);
		chk(k, 32'h405, "tuning duty");
		do_op(TMPIO_OP_AUX, 13'h0015, 2'h0);
		cyc(256);
		count_hi(1'b1, 128, k);
		chk(k, 32'h2a, "aux duty");
		done("converters");
		do_op(TMPIO_OP_SEG, 13'h0003, 2'h0);
		chk(seg_oe, 7'h00, "segments off");
		do_op(TMPIO_OP_OUT_B, 13'h0005, 2'h0);
		ce = 1'b1;
		cyc(5);
		ce = 1'b0;
		cyc(300);
		chk({b_oe, rst_o}, 5'h1e, "short select ignored");
		ce = 1'b1;
		wait_rst();
		chk(seg_oe, 7'h4f, "segment pattern");
		chk({a_oe, b_oe}, 8'h00, "ports input");
		chk({c_oe, m_oe}, 5'h1e, "output ports kept");
		ce = 1'b0;
		cyc(30);
		chk({seg_oe, c_oe}, 10'h007, "deselect gating");
		done("select");
		do_op(TMPIO_OP_OUT_B, 13'h0005, 2'h0);
		do_op(TMPIO_OP_HALT, 13'h0000, 2'h0);
		chk({halt_o, b_oe, c_oe, m_oe}, 10'h200, "halt state");
		count_hi(1'b0, 20, k);
		chk(k, 20, "tuning high halted");
		count_hi(1'b1, 20, k);
		chk(k, 0, "aux low halted");
		do_op(TMPIO_OP_OUT_C, 13'h0007, 2'h0);
		chk(c_oe, 3'h0, "op refused halted");
		ce = 1'b1;
		wait_rst();
		chk({halt_o, c_oe, m_oe}, 6'h00, "wake keeps float");
		do_op(TMPIO_OP_OUT_C, 13'h0003, 2'h0);
		chk({c_oe, c_out}, 6'h3b, "running again");
		done("halt");
		complete_run();
	end
endmodule
